// ===== icc_pkg.sv
// Constants, register map and state encoding of the instruction cache
package icc_pkg;
   // Geometry: 512 lines of 8 words, 32 ways, so 16 sets
   localparam int unsigned ICC_WAYS      = 32;
   localparam int unsigned ICC_SETS      = 16;
   localparam int unsigned ICC_WORDS     = 8;
   localparam int unsigned ICC_WAY_W     = 5;
   localparam int unsigned ICC_SET_W     = 4;
   localparam int unsigned ICC_WORD_W    = 3;
   localparam int unsigned ICC_LINE_W    = ICC_SET_W + ICC_WAY_W;
   localparam int unsigned ICC_DADDR_W   = ICC_LINE_W + ICC_WORD_W;
   // Virtual address fields
   localparam int unsigned ICC_WORD_LSB  = 2;
   localparam int unsigned ICC_SET_LSB   = 5;
   localparam int unsigned ICC_TAG_LSB   = 9;
   localparam int unsigned ICC_TAG_W     = 32 - ICC_TAG_LSB;
   localparam logic [4:0]  ICC_LINE_OFS0 = 5'h00;
   // Register port
   localparam int unsigned ICC_RADDR_W   = 8;
   localparam logic [7:0]  ICC_REG_CTRL  = 8'h04;
   localparam logic [7:0]  ICC_REG_STAT  = 8'h08;
   localparam logic [7:0]  ICC_REG_COPS  = 8'h1c;
   // Control register fields
   localparam int unsigned ICC_CTRL_MMU  = 0;
   localparam int unsigned ICC_CTRL_ICEN = 12;
   localparam logic        ICC_MMU_RST   = 1'b0;
   localparam logic        ICC_ICEN_RST  = 1'b0;
   // Cache operation encodings
   localparam logic [2:0]  ICC_SUBOP_FLUSH = 3'h0;
   localparam logic [3:0]  ICC_OPR_INV_I   = 4'h5;
   localparam logic [3:0]  ICC_OPR_INV_ID  = 4'h7;
   // Reset values and counts
   localparam logic [4:0]  ICC_RR_RST    = 5'h00;
   localparam logic [4:0]  ICC_RR_ONE    = 5'h01;
   localparam logic [2:0]  ICC_BEAT_ONE  = 3'h1;
   localparam logic [2:0]  ICC_BEAT_LAST = 3'h7;
   localparam logic [2:0]  ICC_BEAT_RST  = 3'h0;

   typedef enum logic [1:0]
   {
      ICC_IDLE   = 2'b00,
      ICC_LOOK   = 2'b01,
      ICC_FILL   = 2'b10,
      ICC_SINGLE = 2'b11
   } icc_state_t;
endpackage : icc_pkg

// ===== icc_icache.sv
// Instruction cache: lookup, line fill, enable and invalidate control
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
// How it works
// - Sixteen kilobytes: 512 lines of 32 bytes, 32 ways per set.
// - Set index and tag come from the virtual fetch address.
// - Every refill loads a whole line of eight words.
// - Every fetch is looked up whatever its cacheable attribute.
// - Cacheable miss, or MMU off, fetches a line into the round-robin way.
// - Uncacheable miss with MMU on reads one word, cache untouched.
// - Control register bit 12 enables or disables the cache.
// - One control write sets MMU enable and cache enable together.
// - External reset clears the enable and invalidates every line.
// - Software reset or sleep reset also leaves the cache disabled.
// - When disabled, no allocation, but lookups still hit valid lines.
// - Invalidate command clears all lines at the moment of the write, except a line whose fill completes in that cycle.
// - No snooping of stores; fetches never search the write buffer.
// - Sub-op 0 with operand 5 or 7 invalidates; data ignored.
module icc_icache
(
   input  wire logic                              clock,
   input  wire logic                              resetn,
   input  wire logic                              soft_reset,
   input  wire logic                              sleep_reset,
   input  wire logic [icc_pkg::ICC_RADDR_W-1:0]   reg_addr,
   input  wire logic [31:0]                       reg_wdata,
   input  wire logic                              reg_wr,
   input  wire logic                              reg_rd,
   input  wire logic [2:0]                        coproc_subop_field,
   input  wire logic [3:0]                        coproc_operand_reg_field,
   output logic      [31:0]                       reg_rdata,
   input  wire logic                              fetch_req,
   input  wire logic [31:0]                       fetch_vaddr,
   input  wire logic                              fetch_cacheable,
   output logic                                   fetch_busy,
   output logic                                   fetch_valid,
   output logic      [31:0]                       fetch_data,
   output logic                                   mem_req,
   output logic                                   mem_line,
   output logic      [31:0]                       mem_addr,
   input  wire logic                              mem_rvalid,
   input  wire logic [31:0]                       mem_rdata,
   output logic                                   mmu_enable
);
   import icc_pkg::*;

   // Field extraction from a virtual address
   function automatic logic [ICC_SET_W-1:0] set_of(input logic [31:0] va);
      set_of = va[ICC_SET_LSB +: ICC_SET_W];
   endfunction : set_of

   function automatic logic [ICC_TAG_W-1:0] tag_of(input logic [31:0] va);
      tag_of = va[ICC_TAG_LSB +: ICC_TAG_W];
   endfunction : tag_of

   function automatic logic [ICC_WORD_W-1:0] word_of(input logic [31:0] va);
      word_of = va[ICC_WORD_LSB +: ICC_WORD_W];
   endfunction : word_of

   // 512 lines: 16 sets of 32 ways
   // Storage: data words are kept in an array without reset to stay RAM-like
   logic [31:0]              data_mem [0:ICC_SETS*ICC_WAYS*ICC_WORDS-1];
   logic [ICC_TAG_W-1:0]     tag_mem  [0:ICC_SETS*ICC_WAYS-1];
   logic [ICC_SETS*ICC_WAYS-1:0] valid_q;
   logic [ICC_WAY_W-1:0]     rr_q     [0:ICC_SETS-1];

   icc_state_t               state_q;
   logic [31:0]              va_q;
   logic                     cacheable_q;
   logic                     mmu_q;
   logic                     icen_q;
   logic [ICC_WAY_W-1:0]     victim_q;
   logic [ICC_WORD_W-1:0]    beat_q;
   logic                     fetch_valid_q;
   logic [31:0]              fetch_data_q;
   logic                     mem_req_q;
   logic                     mem_line_q;
   logic [31:0]              mem_addr_q;
   logic [31:0]              rdata_q;
   logic                     last_hit_q;
   logic                     busy_q;

   logic                     hit;
   logic [ICC_WAY_W-1:0]     hit_way;
   logic [31:0]              hit_data;
   logic                     alloc;
   logic                     fill_done;
   logic                     inval;
   logic                     ctrl_wr;
   logic [ICC_LINE_W-1:0]    fill_line;

   // Tag compare across all ways of the addressed set
   // virtual index and tag
   always_comb
   begin
      hit     = 1'b0;
      hit_way = '0;
      for (int w = 0; w < ICC_WAYS; w++)
      begin
         if (valid_q[{set_of(va_q), w[ICC_WAY_W-1:0]}] &&
             tag_mem[{set_of(va_q), w[ICC_WAY_W-1:0]}] == tag_of(va_q))
         begin
            hit     = 1'b1;
            hit_way = w[ICC_WAY_W-1:0];
         end
      end
   end

   assign hit_data  = data_mem[{set_of(va_q), hit_way, word_of(va_q)}];
   // allocate when enabled, on cacheable miss or MMU off
   assign alloc     = icen_q && (cacheable_q || !mmu_q);
   assign fill_done = (state_q == ICC_FILL) && mem_rvalid && (beat_q == ICC_BEAT_LAST);
   assign fill_line = {set_of(va_q), victim_q};
   assign ctrl_wr   = reg_wr && (reg_addr == ICC_REG_CTRL);
   assign inval     = reg_wr && (reg_addr == ICC_REG_COPS) &&
                      (coproc_subop_field == ICC_SUBOP_FLUSH) &&
                      ((coproc_operand_reg_field == ICC_OPR_INV_I) ||
                       (coproc_operand_reg_field == ICC_OPR_INV_ID));

   // Control register: MMU and cache enable, cleared by any reset source
   // both bits from a single write
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         mmu_q  <= ICC_MMU_RST;
         icen_q <= ICC_ICEN_RST;
      end
      else if (soft_reset || sleep_reset)
      begin
         mmu_q  <= ICC_MMU_RST;
         icen_q <= ICC_ICEN_RST;
      end
      else if (ctrl_wr)
      begin
         mmu_q  <= reg_wdata[ICC_CTRL_MMU];
         icen_q <= reg_wdata[ICC_CTRL_ICEN];
      end
   end

   // Line valid bits; a completing fill wins over a same-cycle invalidate
   // reset invalidates all lines
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         valid_q <= '0;
      else
      begin
         if (inval)
            valid_q <= '0;
         if (fill_done)
            valid_q[fill_line] <= 1'b1;
      end
   end

   // Round-robin victim pointers, one per set
   // advance after allocation, wrap 31 to 0
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int s = 0; s < ICC_SETS; s++)
            rr_q[s] <= ICC_RR_RST;
      end
      else if (fill_done)
         rr_q[set_of(va_q)] <= rr_q[set_of(va_q)] + ICC_RR_ONE;
   end

   // Line storage written beat by beat; tag written with the last beat
   // whole line of eight words
   always_ff @(posedge clock)
   begin
      if ((state_q == ICC_FILL) && mem_rvalid)
         data_mem[{fill_line, beat_q}] <= mem_rdata;
      if (fill_done)
         tag_mem[fill_line] <= tag_of(va_q);
   end

   // Fetch sequencer
   // only fetches and memory read data reach the arrays
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q       <= ICC_IDLE;
         va_q          <= '0;
         cacheable_q   <= 1'b0;
         victim_q      <= ICC_RR_RST;
         beat_q        <= ICC_BEAT_RST;
         fetch_valid_q <= 1'b0;
         fetch_data_q  <= '0;
         mem_req_q     <= 1'b0;
         mem_line_q    <= 1'b0;
         mem_addr_q    <= '0;
         last_hit_q    <= 1'b0;
         busy_q        <= 1'b0;
      end
      else
      begin
         fetch_valid_q <= 1'b0;
         mem_req_q     <= 1'b0;
         unique case (state_q)
            ICC_IDLE:
            begin
               if (fetch_req)
               begin
                  va_q        <= fetch_vaddr;
                  cacheable_q <= fetch_cacheable;
                  state_q     <= ICC_LOOK;
                  busy_q      <= 1'b1;
               end
            end
            ICC_LOOK:
            begin
               last_hit_q <= hit;
               if (hit)
               begin
                  fetch_valid_q <= 1'b1;
                  fetch_data_q  <= hit_data;
                  state_q       <= ICC_IDLE;
                  busy_q        <= 1'b0;
               end
               else if (alloc)
               begin
                  mem_req_q  <= 1'b1;
                  mem_line_q <= 1'b1;
                  mem_addr_q <= {va_q[31:ICC_SET_LSB], ICC_LINE_OFS0};
                  victim_q   <= rr_q[set_of(va_q)];
                  beat_q     <= ICC_BEAT_RST;
                  state_q    <= ICC_FILL;
               end
               else
               begin
                  mem_req_q  <= 1'b1;
                  mem_line_q <= 1'b0;
                  mem_addr_q <= va_q;
                  state_q    <= ICC_SINGLE;
               end
            end
            ICC_FILL:
            begin
               if (mem_rvalid)
               begin
                  beat_q <= beat_q + ICC_BEAT_ONE;
                  if (beat_q == word_of(va_q))
                     fetch_data_q <= mem_rdata;
                  if (beat_q == ICC_BEAT_LAST)
                  begin
                     fetch_valid_q <= 1'b1;
                     state_q       <= ICC_IDLE;
                     busy_q        <= 1'b0;
                  end
               end
            end
            ICC_SINGLE:
            begin
               if (mem_rvalid)
               begin
                  fetch_data_q  <= mem_rdata;
                  fetch_valid_q <= 1'b1;
                  state_q       <= ICC_IDLE;
                  busy_q        <= 1'b0;
               end
            end
         endcase
      end
   end

   // Register read port; cache operations register is write-only
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         rdata_q <= '0;
      else if (reg_rd)
      begin
         rdata_q <= '0;
         if (reg_addr == ICC_REG_CTRL)
         begin
            rdata_q[ICC_CTRL_MMU]  <= mmu_q;
            rdata_q[ICC_CTRL_ICEN] <= icen_q;
         end
         else if (reg_addr == ICC_REG_STAT)
            rdata_q <= {29'h0000000, last_hit_q, state_q};
      end
   end

   assign reg_rdata   = rdata_q;
   assign fetch_busy  = busy_q;  // Registered copy of "state not idle"
   assign fetch_valid = fetch_valid_q;
   assign fetch_data  = fetch_data_q;
   assign mem_req     = mem_req_q;
   assign mem_line    = mem_line_q;
   assign mem_addr    = mem_addr_q;
   assign mmu_enable  = mmu_q;

   // Hit returns the stored word on the next cycle
   hit_reply_a: assert property (@(posedge clock) disable iff (!resetn)
      (state_q == ICC_LOOK) && hit |=> fetch_valid_q && (fetch_data_q == $past(hit_data)))
      else $error("hit did not return cached word");

   // Allocating miss requests an aligned line
   line_fill_a: assert property (@(posedge clock) disable iff (!resetn)
      (state_q == ICC_LOOK) && !hit && alloc |=>
         mem_req_q && mem_line_q && (mem_addr_q[ICC_SET_LSB-1:0] == ICC_LINE_OFS0))
      else $error("allocating miss did not request a line");

   // Uncached miss asks for one word and never fills
   single_word_a: assert property (@(posedge clock) disable iff (!resetn)
      (state_q == ICC_LOOK) && !hit && !alloc |=> mem_req_q && !mem_line_q && (state_q == ICC_SINGLE))
      else $error("uncached miss not a single read");

   // Disabled cache never starts a line fill
   no_alloc_off_a: assert property (@(posedge clock) disable iff (!resetn)
      (state_q == ICC_LOOK) && !icen_q |=> !(mem_req_q && mem_line_q))
      else $error("line fill while disabled");

   // One control write loads both enables
   ctrl_write_a: assert property (@(posedge clock) disable iff (!resetn)
      ctrl_wr && !soft_reset && !sleep_reset |=>
         (icen_q == $past(reg_wdata[ICC_CTRL_ICEN])) && (mmu_q == $past(reg_wdata[ICC_CTRL_MMU])))
      else $error("control write did not load enables");

   // Software and sleep reset clear the enable
   soft_disable_a: assert property (@(posedge clock) disable iff (!resetn)
      soft_reset || sleep_reset |=> !icen_q)
      else $error("cache still enabled after soft reset");

   // Invalidate leaves at most the completing line valid
   inval_all_a: assert property (@(posedge clock) disable iff (!resetn)
      inval && !fill_done |=> (valid_q == '0))
      else $error("invalidate left valid lines");

   // Victim pointer steps by one per allocation
   rr_step_a: assert property (@(posedge clock) disable iff (!resetn)
      fill_done |=> (rr_q[set_of(va_q)] == $past(rr_q[set_of(va_q)]) + ICC_RR_ONE))
      else $error("round-robin pointer did not advance");

   // A fill lasts exactly eight beats before the reply
   fill_beats_a: assert property (@(posedge clock) disable iff (!resetn)
      (state_q == ICC_FILL) && mem_rvalid && (beat_q == ICC_BEAT_LAST) |=> fetch_valid_q && valid_q[$past(fill_line)])
      else $error("line not installed after eighth beat");
endmodule : icc_icache

// ===== icc_mem_model.sv
// Behavioural external memory answering the instruction cache's reads
`timescale 1ns/100ps
module icc_mem_model
(
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        slow,
   input  wire logic        mem_req,
   input  wire logic        mem_line,
   input  wire logic [31:0] mem_addr,
   output logic             mem_rvalid,
   output logic      [31:0] mem_rdata
);
   logic [31:0] base_q;
   logic [3:0]  left_q;
   logic [1:0]  wait_q;

   // Beat generator; data is a fixed function of the word address
   // eight beats per line, one beat for a single word
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         left_q     <= 4'h0;
         wait_q     <= 2'h0;
         base_q     <= 32'h0;
         mem_rvalid <= 1'b0;
         mem_rdata  <= 32'h0;
      end
      else
      begin
         mem_rvalid <= 1'b0;
         mem_rdata  <= ~mem_rdata;  // Never leave a stale word that could pass for data
         if (mem_req)
         begin
            base_q <= mem_line ? {mem_addr[31:5], 5'h00} : {mem_addr[31:2], 2'h0};
            left_q <= mem_line ? 4'h8 : 4'h1;
            wait_q <= slow ? 2'h3 : 2'h0;
         end
         else if (left_q != 4'h0)
         begin
            if (wait_q != 2'h0)
               wait_q <= wait_q - 2'h1;
            else
            begin
               mem_rvalid <= 1'b1;
               mem_rdata  <= base_q ^ 32'h5a5a_5a5a;
               base_q     <= base_q + 32'h4;
               left_q     <= left_q - 4'h1;
               wait_q     <= slow ? 2'h2 : 2'h0;
            end
         end
      end
   end
endmodule : icc_mem_model

// ===== tb.sv
// Self-checking bench for the instruction cache
`timescale 1ns/100ps
module tb;
   import icc_pkg::*;
   logic        clock, resetn, soft_reset, sleep_reset, reg_wr, reg_rd, slow;
   logic        fetch_req, fetch_cacheable, fetch_busy, fetch_valid;
   logic        mem_req, mem_line, mem_rvalid, mmu_enable;
   logic [7:0]  reg_addr;
   logic [2:0]  subop;
   logic [3:0]  opr;
   logic [31:0] reg_wdata, reg_rdata, fetch_vaddr, fetch_data, mem_addr, mem_rdata;
   int          miscompares, n_tests;

   icc_icache icc_icache_inst (.clock(clock), .resetn(resetn), .soft_reset(soft_reset),
      .sleep_reset(sleep_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .coproc_subop_field(subop), .coproc_operand_reg_field(opr),
      .reg_rdata(reg_rdata), .fetch_req(fetch_req), .fetch_vaddr(fetch_vaddr),
      .fetch_cacheable(fetch_cacheable), .fetch_busy(fetch_busy), .fetch_valid(fetch_valid),
      .fetch_data(fetch_data), .mem_req(mem_req), .mem_line(mem_line), .mem_addr(mem_addr),
      .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .mmu_enable(mmu_enable));
   icc_mem_model icc_mem_model_inst (.clock(clock), .resetn(resetn), .slow(slow), .mem_req(mem_req),
      .mem_line(mem_line), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

   // Clock at 50 MHz
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] so, input logic [3:0] op);
      reg_addr  <= a;
      reg_wdata <= d;
      subop     <= so;
      opr       <= op;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", exp, reg_rdata);
      @(posedge clock);
   endtask : rd

   // Kind: 0 hit, 1 line fill, 2 single word read
   task automatic fetch(input logic [31:0] a, input logic c, input int kind);
      int          n;
      int          nreq;
      logic        ln;
      logic [31:0] ma;
      fetch_req       <= 1'b1;
      fetch_vaddr     <= a;
      fetch_cacheable <= c;
      @(posedge clock);
      fetch_req <= 1'b0;
      n    = 0;
      nreq = 0;
      ln   = 1'b0;
      ma   = 32'h0;
      #1;
      chk("fetch_busy", 32'h1, fetch_busy);
      while (fetch_valid !== 1'b1 && n < 300)
      begin
         @(posedge clock);
         #1;
         if (mem_req === 1'b1)
         begin
            nreq++;
            ln = mem_line;
            ma = mem_addr;
         end
         n++;
      end
      if (n >= 300)
      begin
         miscompares++;
         conclude();
      end
      chk("fetch_busy", 32'h0, fetch_busy);
      chk("fetch_data", {a[31:2], 2'h0} ^ 32'h5a5a_5a5a, fetch_data);
      chk("mem requests", (kind == 0) ? 32'h0 : 32'h1, nreq);
      if (kind == 0)
         chk("hit latency", 32'h1, n);
      else
         chk("mem_addr", (kind == 1) ? {a[31:5], 5'h00} : a, ma);
      if (kind != 0)
         chk("mem_line", (kind == 1), ln);
      @(posedge clock);
   endtask : fetch

   function automatic logic [31:0] way_addr(input int t);
      return (t << 9) | 32'h60;
   endfunction : way_addr

   task automatic t_reset_state();
      rd(ICC_REG_CTRL, 32'h0);
      chk("mmu_enable", 1'b0, mmu_enable);
      rd(8'h10, 32'h0);
      fetch(32'h0000_0044, 1'b1, 2);
      fetch(32'h0000_0044, 1'b1, 2);
   endtask : t_reset_state

   task automatic t_enable_fill();
      wr(ICC_REG_CTRL, 32'h1001, 3'h0, 4'h0);
      chk("mmu_enable", 1'b1, mmu_enable);
      rd(ICC_REG_CTRL, 32'h1001);
      fetch(32'h0000_1024, 1'b1, 1);
      fetch(32'h0000_103c, 1'b0, 0);
      rd(ICC_REG_STAT, 32'h4);
      fetch(32'h0000_8848, 1'b0, 2);
      fetch(32'h0000_8848, 1'b0, 2);
      wr(ICC_REG_CTRL, 32'h1000, 3'h0, 4'h0);
      slow <= 1'b1;
      fetch(32'h0000_2050, 1'b0, 1);
      slow <= 1'b0;
      fetch(32'h0000_2054, 1'b0, 0);
   endtask : t_enable_fill

   // Fill every way of one set, wrapping the pointer to 0, then one more fill to evict way 0
   task automatic t_round_robin();
      for (int t = 0; t < 32; t++)
         fetch(way_addr(t), 1'b1, 1);
      fetch(way_addr(0), 1'b1, 0);
      fetch(way_addr(32), 1'b1, 1);
      fetch(way_addr(1), 1'b1, 0);
      fetch(way_addr(0), 1'b1, 1);
   endtask : t_round_robin

   task automatic t_disabled();
      wr(ICC_REG_CTRL, 32'h0, 3'h0, 4'h0);
      fetch(way_addr(2), 1'b1, 0);
      fetch(way_addr(40), 1'b1, 2);
      fetch(way_addr(40), 1'b1, 2);
   endtask : t_disabled

   task automatic t_invalidate();
      wr(ICC_REG_CTRL, 32'h1000, 3'h0, 4'h0);
      wr(ICC_REG_COPS, 32'hffff_ffff, 3'h0, 4'h6);
      wr(ICC_REG_COPS, 32'h0, 3'h1, 4'h5);
      fetch(32'h0000_1024, 1'b1, 0);
      wr(ICC_REG_COPS, 32'hffff_ffff, ICC_SUBOP_FLUSH, ICC_OPR_INV_I);
      fetch(32'h0000_1024, 1'b1, 1);
      wr(ICC_REG_COPS, 32'h0, ICC_SUBOP_FLUSH, ICC_OPR_INV_ID);
      fetch(32'h0000_1024, 1'b1, 1);
      rd(ICC_REG_COPS, 32'h0);
   endtask : t_invalidate

   task automatic t_resets();
      soft_reset <= 1'b1;
      @(posedge clock);
      soft_reset <= 1'b0;
      @(posedge clock);
      rd(ICC_REG_CTRL, 32'h0);
      fetch(32'h0000_1024, 1'b1, 0);
      wr(ICC_REG_CTRL, 32'h1001, 3'h0, 4'h0);
      sleep_reset <= 1'b1;
      @(posedge clock);
      sleep_reset <= 1'b0;
      @(posedge clock);
      rd(ICC_REG_CTRL, 32'h0);
      chk("mmu_enable", 1'b0, mmu_enable);
      wr(ICC_REG_CTRL, 32'h1001, 3'h0, 4'h0);
      resetn <= 1'b0;
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      rd(ICC_REG_CTRL, 32'h0);
      wr(ICC_REG_CTRL, 32'h1000, 3'h0, 4'h0);
      fetch(32'h0000_1024, 1'b1, 1);
   endtask : t_resets

   // Main sequence
   initial
   begin
      miscompares = 0;
      n_tests     = 0;
      {resetn, soft_reset, sleep_reset, reg_wr, reg_rd, fetch_req, fetch_cacheable, slow} = 8'h0;
      {reg_addr, subop, opr, reg_wdata, fetch_vaddr} = 79'h0;
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      t_reset_state();
      t_enable_fill();
      t_round_robin();
      t_disabled();
      t_invalidate();
      t_resets();
      conclude();
   end
endmodule : tb
